/* hdl/calendar_clock_unit_ctrl.sv */
// Control and status register of the calendar clock unit.
// Assumes i_rst_n is the power-on reset only; other resets arrive as
// i_warm_rst, a one-cycle pulse on i_clock. Timekeeping core pulses are
// on i_clock; oscillator status levels are asynchronous.
`timescale 1ns/100ps
`include "calendar_clock_unit_params.svh"

// Summary of operation
// - Bits 25:16 hold signed ten-bit trim
// - Negative trim removes pulses each minute
// - Positive trim adds pulses; zero does nothing
// - Bit 15 switches the unit on
// - On bit writable only while unlock set
// - Unlock bit sets only during system unlock
// - Idle stop gates bus clock in idle
// - Bit 7 picks seconds clock or alarm
// - Pin driven only while bit 0 set
// - Bit 6 reports oscillator running
// - Half-second flag cleared by seconds write
// - Control bits reset only at power-on; warm reset clears half flag
// - Unimplemented bits read zero, ignore writes
module calendar_clock_unit_ctrl
  import calendar_clock_unit_pkg::*;
#(
  parameter int ADDR_W = `CALENDAR_CLOCK_UNIT_ADDR_W,
  parameter int CAL_W  = 10
)
(
  // Clock and resets
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_warm_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [31:0]            o_rdata,
  // System control
  input  wire logic              i_unlock_ok,
  input  wire logic              i_cpu_idle,
  output logic                   o_bus_clk_en,
  // Oscillator status, asynchronous
  input  wire logic              i_osc_running,
  input  wire logic              i_rollover_sync,
  // Timekeeping core
  input  wire logic              i_half_sec_tick,
  input  wire logic              i_sec_clk,
  input  wire logic              i_alarm_pulse,
  input  wire logic              i_minute_tick,
  input  wire logic              i_osc_tick,
  input  wire logic [31:0]       i_time_value,
  output logic                   o_time_wr,
  output logic [31:0]            o_time_wdata,
  output logic                   o_module_on,
  output logic [CAL_W-1:0]       o_cal_value,
  output logic                   o_trim_add,
  output logic                   o_trim_drop,
  output logic                   o_trim_busy,
  // Output pin
  output logic                   o_pin_out,
  output logic                   o_pin_oe
);

  // Control fields
  calendar_clock_unit_cal_t     cal_r;
  calendar_clock_unit_cal_t     cal_nxt;
  logic          on_r;
  logic          on_nxt;
  logic          idle_stop_r;
  logic          idle_stop_nxt;
  logic          pin_source_select_r;
  logic          pin_source_select_nxt;
  logic          write_unlock_enable_r;
  logic          write_unlock_enable_nxt;
  logic          pin_output_enable_r;
  logic          pin_output_enable_nxt;

  // Status and path state
  logic          half_second_flag_r;
  logic          half_second_flag_nxt;
  logic [1:0]    sync_a_r;
  logic [1:0]    sync_a_nxt;
  logic [1:0]    sync_b_r;
  logic [1:0]    sync_b_nxt;
  logic [31:0]   rdata_r;
  logic [31:0]   rdata_nxt;
  logic          time_wr_r;
  logic          time_wr_nxt;
  logic [31:0]   time_wdata_r;
  logic [31:0]   time_wdata_nxt;
  logic          pin_out_r;
  logic          pin_out_nxt;
  logic          bus_clk_en_r;
  logic          bus_clk_en_nxt;

  // Decoded accesses
  logic          ctrl_wr;
  logic          time_wr;
  logic          osc_running_flag;
  logic          rollover_sync_flag;
  logic [31:0]   ctrl_image;

  assign ctrl_wr = i_wr && (i_addr == `CALENDAR_CLOCK_UNIT_CTRL_OFS);
  assign time_wr = i_wr && (i_addr == `CALENDAR_CLOCK_UNIT_TIME_OFS);

  assign osc_running_flag   = sync_b_r[0];
  assign rollover_sync_flag = sync_b_r[1];

  // Control register: software-steered fields
  always_comb
  begin
    cal_nxt                 = cal_r;
    on_nxt                  = on_r;
    idle_stop_nxt           = idle_stop_r;
    pin_source_select_nxt   = pin_source_select_r;
    write_unlock_enable_nxt = write_unlock_enable_r;
    pin_output_enable_nxt   = pin_output_enable_r;
    if (ctrl_wr)
    begin
      cal_nxt = i_wdata[`CALENDAR_CLOCK_UNIT_CAL_MSB:`CALENDAR_CLOCK_UNIT_CAL_LSB];
      // Switch-on state guarded by the unlock bit as it stands now
      if (write_unlock_enable_r)
        on_nxt = i_wdata[`CALENDAR_CLOCK_UNIT_ON_BIT];
      idle_stop_nxt         = i_wdata[`CALENDAR_CLOCK_UNIT_IDLE_BIT];
      pin_source_select_nxt = i_wdata[`CALENDAR_CLOCK_UNIT_SEL_BIT];
      pin_output_enable_nxt = i_wdata[`CALENDAR_CLOCK_UNIT_OE_BIT];
      // Clearing is always allowed; a set needs the system unlock
      write_unlock_enable_nxt = i_wdata[`CALENDAR_CLOCK_UNIT_WREN_BIT]
                                && (i_unlock_ok
                                    || write_unlock_enable_r);
    end
  end

  // Power-on reset only; warm resets leave these untouched
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cal_r                 <= `CALENDAR_CLOCK_UNIT_CAL_RST;
      on_r                  <= 1'b0;
      idle_stop_r           <= 1'b0;
      pin_source_select_r   <= 1'b0;
      write_unlock_enable_r <= 1'b0;
      pin_output_enable_r   <= 1'b0;
    end
    else
    begin
      cal_r                 <= cal_nxt;
      on_r                  <= on_nxt;
      idle_stop_r           <= idle_stop_nxt;
      pin_source_select_r   <= pin_source_select_nxt;
      write_unlock_enable_r <= write_unlock_enable_nxt;
      pin_output_enable_r   <= pin_output_enable_nxt;
    end
  end

  // Oscillator status synchronisers; first stage feeds second only
  always_comb
  begin
    sync_a_nxt = {i_rollover_sync, i_osc_running};
    sync_b_nxt = sync_a_r;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync_a_r <= 2'h0;
      sync_b_r <= 2'h0;
    end
    else
    begin
      sync_a_r <= sync_a_nxt;
      sync_b_r <= sync_b_nxt;
    end
  end

  // Half-second flag follows the core; seconds write clears it.
  // A tick in the same cycle as the write wins, so no half second is lost.
  always_comb
  begin
    half_second_flag_nxt = half_second_flag_r;
    if (i_warm_rst)
      half_second_flag_nxt = 1'b0;
    else if (i_half_sec_tick)
      half_second_flag_nxt = !half_second_flag_r || time_wr;
    else if (time_wr)
      half_second_flag_nxt = 1'b0;
  end

  // Time register writes pass on to the core with the seconds fields
  always_comb
  begin
    time_wr_nxt    = time_wr;
    time_wdata_nxt = time_wr ? i_wdata : time_wdata_r;
  end

  // Read image; unimplemented positions are constant zero
  always_comb
  begin
    ctrl_image                                = `CALENDAR_CLOCK_UNIT_CTRL_RST;
    ctrl_image[`CALENDAR_CLOCK_UNIT_CAL_MSB:`CALENDAR_CLOCK_UNIT_CAL_LSB]   = cal_r;
    ctrl_image[`CALENDAR_CLOCK_UNIT_ON_BIT]                  = on_r;
    ctrl_image[`CALENDAR_CLOCK_UNIT_IDLE_BIT]                = idle_stop_r;
    ctrl_image[`CALENDAR_CLOCK_UNIT_SEL_BIT]                 = pin_source_select_r;
    ctrl_image[`CALENDAR_CLOCK_UNIT_RUN_BIT]                 = osc_running_flag;
    ctrl_image[`CALENDAR_CLOCK_UNIT_WREN_BIT]                = write_unlock_enable_r;
    ctrl_image[`CALENDAR_CLOCK_UNIT_SYNC_BIT]                = rollover_sync_flag;
    ctrl_image[`CALENDAR_CLOCK_UNIT_HALF_BIT]                = half_second_flag_r;
    ctrl_image[`CALENDAR_CLOCK_UNIT_OE_BIT]                  = pin_output_enable_r;
  end

  // Read data stands for one cycle only; unmapped reads return zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (i_rd)
    begin
      case (i_addr)
        `CALENDAR_CLOCK_UNIT_CTRL_OFS: rdata_nxt = ctrl_image;
        `CALENDAR_CLOCK_UNIT_TIME_OFS: rdata_nxt = i_time_value;
        default:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Pin and bus-clock gating, registered to keep glitches off the pin
  always_comb
  begin
    pin_out_nxt = 1'b0;
    if (pin_output_enable_r)
      pin_out_nxt = pin_source_select_r ? i_sec_clk
                                        : i_alarm_pulse;
    bus_clk_en_nxt = !(idle_stop_r && i_cpu_idle);
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      half_second_flag_r <= 1'b0;
      rdata_r            <= 32'h0000_0000;
      time_wr_r          <= 1'b0;
      time_wdata_r       <= 32'h0000_0000;
      pin_out_r          <= 1'b0;
      bus_clk_en_r       <= 1'b1;
    end
    else
    begin
      half_second_flag_r <= half_second_flag_nxt;
      rdata_r            <= i_warm_rst ? 32'h0000_0000 : rdata_nxt;
      time_wr_r          <= time_wr_nxt;
      time_wdata_r       <= time_wdata_nxt;
      pin_out_r          <= pin_out_nxt;
      bus_clk_en_r       <= bus_clk_en_nxt;
    end
  end

  // Drift trim runs only while the unit is on
  calendar_clock_unit_trim #(
    .CAL_W         (CAL_W)
  ) u_trim (
    .i_clock       (i_clock),
    .i_rst_n       (i_rst_n),
    .i_enable      (on_r),
    .i_cal         (cal_r),
    .i_minute_tick (i_minute_tick),
    .i_osc_tick    (i_osc_tick),
    .o_add         (o_trim_add),
    .o_drop        (o_trim_drop),
    .o_busy        (o_trim_busy)
  );

  // Software must leave a gap after switch-off; no stall is offered
  assign o_module_on  = on_r;
  assign o_cal_value  = cal_r;
  assign o_rdata      = rdata_r;
  assign o_time_wr    = time_wr_r;
  assign o_time_wdata = time_wdata_r;
  assign o_pin_out    = pin_out_r;
  assign o_pin_oe     = pin_output_enable_r;
  assign o_bus_clk_en = bus_clk_en_r;

endmodule : calendar_clock_unit_ctrl

/* hdl/calendar_clock_unit_params.svh */
// Constants for the calendar clock unit control register block.
// Assumes inclusion by bare name from design files only.
`ifndef CALENDAR_CLOCK_UNIT_PARAMS_SVH
`define CALENDAR_CLOCK_UNIT_PARAMS_SVH

// Register byte offsets on the plain register port
`define CALENDAR_CLOCK_UNIT_ADDR_W       4
`define CALENDAR_CLOCK_UNIT_CTRL_OFS     4'h0
`define CALENDAR_CLOCK_UNIT_TIME_OFS     4'h4

// Control register field positions
`define CALENDAR_CLOCK_UNIT_CAL_MSB      25
`define CALENDAR_CLOCK_UNIT_CAL_LSB      16
`define CALENDAR_CLOCK_UNIT_ON_BIT       15
`define CALENDAR_CLOCK_UNIT_IDLE_BIT     13
`define CALENDAR_CLOCK_UNIT_SEL_BIT      7
`define CALENDAR_CLOCK_UNIT_RUN_BIT      6
`define CALENDAR_CLOCK_UNIT_WREN_BIT     3
`define CALENDAR_CLOCK_UNIT_SYNC_BIT     2
`define CALENDAR_CLOCK_UNIT_HALF_BIT     1
`define CALENDAR_CLOCK_UNIT_OE_BIT       0

// Seconds fields of the time value register
`define CALENDAR_CLOCK_UNIT_SEC_MSB      14
`define CALENDAR_CLOCK_UNIT_SEC_LSB      8

// Reset values
`define CALENDAR_CLOCK_UNIT_CAL_RST      10'h000
`define CALENDAR_CLOCK_UNIT_CTRL_RST     32'h0000_0000
`define CALENDAR_CLOCK_UNIT_CNT_RST      11'h000

`endif

/* hdl/calendar_clock_unit_pkg.sv */
// Types shared by the calendar clock unit control logic.
// Assumes the constants header is available alongside.
package calendar_clock_unit_pkg;

  typedef logic [9:0] calendar_clock_unit_cal_t;

  typedef enum logic {
    CALENDAR_CLOCK_UNIT_TRIM_IDLE,
    CALENDAR_CLOCK_UNIT_TRIM_RUN
  } calendar_clock_unit_trim_state_e;

endpackage : calendar_clock_unit_pkg

/* hdl/calendar_clock_unit_trim.sv */
// Drift trim sequencer: adds or removes oscillator pulses once a minute.
// Assumes minute and oscillator ticks are single-cycle pulses on i_clock.
`timescale 1ns/100ps
`include "calendar_clock_unit_params.svh"

module calendar_clock_unit_trim
  import calendar_clock_unit_pkg::*;
#(
  parameter int CAL_W = 10
)
(
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // Control
  input  wire logic             i_enable,
  input  wire logic [CAL_W-1:0] i_cal,
  // Timebase
  input  wire logic             i_minute_tick,
  input  wire logic             i_osc_tick,
  // Correction pulses
  output logic                  o_add,
  output logic                  o_drop,
  output logic                  o_busy
);

  calendar_clock_unit_trim_state_e   state_r;
  calendar_clock_unit_trim_state_e   state_nxt;
  logic [CAL_W:0]     count_r;
  logic [CAL_W:0]     count_nxt;
  logic               neg_r;
  logic               neg_nxt;
  logic               add_r;
  logic               add_nxt;
  logic               drop_r;
  logic               drop_nxt;
  logic [CAL_W:0]     cal_ext;
  logic [CAL_W:0]     magnitude;

  // Sign-extended trim; top-bit-only pattern gives the largest magnitude
  assign cal_ext   = {i_cal[CAL_W-1], i_cal};
  assign magnitude = i_cal[CAL_W-1] ? ((CAL_W+1)'(0) - cal_ext)
                                    : cal_ext;

  always_comb
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    neg_nxt   = neg_r;
    add_nxt   = 1'b0;
    drop_nxt  = 1'b0;
    case (state_r)
      CALENDAR_CLOCK_UNIT_TRIM_IDLE:
      begin
        // Zero trim never leaves idle
        if (i_enable && i_minute_tick && (magnitude != '0))
        begin
          count_nxt = magnitude;
          neg_nxt   = i_cal[CAL_W-1];
          state_nxt = CALENDAR_CLOCK_UNIT_TRIM_RUN;
        end
      end
      CALENDAR_CLOCK_UNIT_TRIM_RUN:
      begin
        if (!i_enable)
        begin
          count_nxt = '0;
          state_nxt = CALENDAR_CLOCK_UNIT_TRIM_IDLE;
        end
        else if (i_osc_tick)
        begin
          drop_nxt  = neg_r;
          add_nxt   = !neg_r;
          count_nxt = count_r - (CAL_W+1)'(1);
          if (count_r == (CAL_W+1)'(1))
            state_nxt = CALENDAR_CLOCK_UNIT_TRIM_IDLE;
        end
      end
      default:
      begin
        state_nxt = CALENDAR_CLOCK_UNIT_TRIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= CALENDAR_CLOCK_UNIT_TRIM_IDLE;
      count_r <= `CALENDAR_CLOCK_UNIT_CNT_RST;
      neg_r   <= 1'b0;
      add_r   <= 1'b0;
      drop_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      neg_r   <= neg_nxt;
      add_r   <= add_nxt;
      drop_r  <= drop_nxt;
    end
  end

  assign o_add  = add_r;
  assign o_drop = drop_r;
  assign o_busy = (state_r == CALENDAR_CLOCK_UNIT_TRIM_RUN);

endmodule : calendar_clock_unit_trim

/* verif/calendar_clock_unit_ctrl_asserts.sv */
// Checker for the calendar clock unit control register.
// Assumes binding into calendar_clock_unit_ctrl; sees only its ports.
`timescale 1ns/100ps

module calendar_clock_unit_ctrl_asserts #(
  parameter int ADDR_W = 4,
  parameter int CAL_W  = 10
)
(
  // Clock, reset and register port
  input wire logic              i_clock,
  input wire logic              i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [31:0]       o_rdata,
  // System, pin and timekeeping
  input wire logic              i_cpu_idle,
  input wire logic              i_sec_clk,
  input wire logic              i_alarm_pulse,
  input wire logic              i_osc_tick,
  input wire logic              o_bus_clk_en,
  input wire logic              o_pin_out,
  input wire logic              o_pin_oe,
  input wire logic              o_module_on,
  input wire logic [CAL_W-1:0]  o_cal_value,
  input wire logic              o_time_wr,
  input wire logic [31:0]       o_time_wdata,
  input wire logic              o_trim_add,
  input wire logic              o_trim_drop,
  input wire logic              o_trim_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // Shadow of select and idle-stop bits
  logic sel_r;
  logic sel_nxt;
  logic idle_r;
  logic idle_nxt;
  logic pick;
  logic gate;

  assign pick = sel_r ? i_sec_clk : i_alarm_pulse;
  assign gate = idle_r & i_cpu_idle;

  always_comb
  begin
    sel_nxt = sel_r;
    idle_nxt = idle_r;
    if (i_wr && i_addr == '0)
    begin
      sel_nxt = i_wdata[7];
      idle_nxt = i_wdata[13];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n) {sel_r, idle_r} <= 2'b00;
    else {sel_r, idle_r} <= {sel_nxt, idle_nxt};

  sequence s_ctrl_wr;
    i_wr && i_addr == '0;
  endsequence
  sequence s_time_wr;
    i_wr && i_addr == ADDR_W'(4);
  endsequence
  sequence s_ctrl_rd;
    i_rd && i_addr == '0;
  endsequence

  cal_write_a: assert property (s_ctrl_wr |=>
    o_cal_value == $past(i_wdata[25:16])) else $error("cal field wrong");
  on_cause_a: assert property ($changed(o_module_on) |->
    $past(i_wr) && $past(i_addr) == '0) else $error("on bit moved");
  on_image_a: assert property (s_ctrl_rd |=>
    o_rdata[15] == o_module_on) else $error("on bit readback");
  unimpl_zero_a: assert property (s_ctrl_rd |=>
    (o_rdata & 32'hFC00_5F30) == 32'h0) else $error("reserved not zero");
  oe_write_a: assert property (s_ctrl_wr |=>
    o_pin_oe == $past(i_wdata[0])) else $error("oe bit wrong");
  pin_off_a: assert property (!o_pin_oe |=> !o_pin_out)
    else $error("pin driven while off");
  pin_src_a: assert property (o_pin_oe |=> o_pin_out == $past(pick))
    else $error("pin source wrong");
  idle_gate_a: assert property (o_bus_clk_en == !$past(gate))
    else $error("bus clock gate wrong");
  time_wr_a: assert property (s_time_wr |=>
    o_time_wr && o_time_wdata == $past(i_wdata)) else $error("time write");
  trim_cause_a: assert property (o_trim_add || o_trim_drop |->
    $past(i_osc_tick) && !(o_trim_add && o_trim_drop))
    else $error("stray trim pulse");
  trim_sign_a: assert property (o_trim_add || o_trim_drop |->
    o_trim_drop == o_cal_value[CAL_W-1]) else $error("trim sign wrong");
  // A correction pulse only comes out of a running sequence
  trim_busy_a: assert property (o_trim_add || o_trim_drop |->
    $past(o_trim_busy)) else $error("trim pulse while idle");

endmodule : calendar_clock_unit_ctrl_asserts

bind calendar_clock_unit_ctrl calendar_clock_unit_ctrl_asserts #(.ADDR_W(ADDR_W), .CAL_W(CAL_W)) u_chk (.*);

/* verif/rtc_control_calibration_tb_top.sv */
// Self-checking bench for the calendar clock unit control register.
// Assumes calendar_clock_unit_ctrl with default parameters and the bound checker.
`timescale 1ns/100ps

module rtc_control_calibration_tb_top;
  logic i_clock = 0, i_rst_n = 0, i_warm_rst = 0, i_wr = 0, i_rd = 0;
  logic i_unlock_ok = 0, i_cpu_idle = 0, i_osc_running = 0;
  logic i_rollover_sync = 0, i_half_sec_tick = 0, i_sec_clk = 0;
  logic i_alarm_pulse = 0, i_minute_tick = 0, i_osc_tick = 0;
  logic [3:0]  i_addr = '0;
  logic [31:0] i_wdata = '0, i_time_value = '0, o_rdata, o_time_wdata;
  logic o_bus_clk_en, o_time_wr, o_module_on, o_trim_add, o_trim_drop;
  logic o_trim_busy, o_pin_out, o_pin_oe, rd_d = 0;
  logic [9:0]  o_cal_value;
  logic [31:0] exp_q [$];
  logic [31:0] w;
  // Trim cases: control word, expected adds, expected drops
  logic [31:0] tw [6] = '{32'h0003_8008, 32'h03FF_8008, 32'h0200_8008,
                         32'h01FF_8008, 32'h0005_0008, 32'h0000_8008};
  logic [31:0] ta [6] = '{3, 0, 0, 511, 0, 0};
  logic [31:0] td [6] = '{0, 1, 512, 0, 0, 0};
  int fail_count = 0, checks_done = 0, cyc = 0, n_add = 0, n_drop = 0;

  calendar_clock_unit_ctrl DUT (
    .i_clock         (i_clock),
    .i_rst_n         (i_rst_n),
    .i_warm_rst      (i_warm_rst),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .i_unlock_ok     (i_unlock_ok),
    .i_cpu_idle      (i_cpu_idle),
    .o_bus_clk_en    (o_bus_clk_en),
    .i_osc_running   (i_osc_running),
    .i_rollover_sync (i_rollover_sync),
    .i_half_sec_tick (i_half_sec_tick),
    .i_sec_clk       (i_sec_clk),
    .i_alarm_pulse   (i_alarm_pulse),
    .i_minute_tick   (i_minute_tick),
    .i_osc_tick      (i_osc_tick),
    .i_time_value    (i_time_value),
    .o_time_wr       (o_time_wr),
    .o_time_wdata    (o_time_wdata),
    .o_module_on     (o_module_on),
    .o_cal_value     (o_cal_value),
    .o_trim_add      (o_trim_add),
    .o_trim_drop     (o_trim_drop),
    .o_trim_busy     (o_trim_busy),
    .o_pin_out       (o_pin_out),
    .o_pin_oe        (o_pin_oe)
  );

  initial forever #2 i_clock = ~i_clock;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One gap cycle after each strobe keeps drivers single-assigned
  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask : wr32

  task automatic rd32(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
  endtask : rd32

  always @(posedge i_clock)
  begin
    if (rd_d) chk(o_rdata, exp_q.pop_front());
    rd_d <= i_rd;
    n_add += (o_trim_add === 1'b1);
    n_drop += (o_trim_drop === 1'b1);
    i_sec_clk <= 1'($urandom);
    i_alarm_pulse <= 1'($urandom);
    i_cpu_idle <= 1'($urandom);
    if (++cyc == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  initial
  begin
    void'($urandom(1));
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    rd32(4'h0, 32'h0000_0000);
    rd32(4'hC, 32'h0000_0000);
    w = $urandom;
    wr32(4'h0, w);
    rd32(4'h0, w & 32'h03FF_2081);
    i_unlock_ok <= 1'b1;
    wr32(4'h0, 32'h0000_0008);
    i_unlock_ok <= 1'b0;
    wr32(4'h0, 32'hFFFF_FFFF);
    rd32(4'h0, 32'h03FF_A089);
    $display("test lock done");
    i_warm_rst <= 1'b1;
    @(posedge i_clock);
    i_warm_rst <= 1'b0;
    rd32(4'h0, 32'h03FF_A089);
    i_osc_running <= 1'b1;
    i_rollover_sync <= 1'b1;
    repeat (4) @(posedge i_clock);
    rd32(4'h0, 32'h03FF_A0CD);
    i_half_sec_tick <= 1'b1;
    @(posedge i_clock);
    i_half_sec_tick <= 1'b0;
    rd32(4'h0, 32'h03FF_A0CF);
    w = $urandom;
    i_time_value <= w;
    wr32(4'h4, ~w);
    rd32(4'h0, 32'h03FF_A0CD);
    rd32(4'h4, w);
    $display("test status done");
    // Switch-off; the write task's idle cycle keeps the bus quiet after it
    wr32(4'h0, 32'h0000_0000);
    wr32(4'h0, 32'h0000_8000);
    rd32(4'h0, 32'h0000_0044);
    i_unlock_ok <= 1'b1;
    wr32(4'h0, 32'h0000_0008);
    i_unlock_ok <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      wr32(4'h0, tw[k]);
      n_add = 0;
      n_drop = 0;
      i_minute_tick <= 1'b1;
      @(posedge i_clock);
      i_minute_tick <= 1'b0;
      repeat (530)
      begin
        i_osc_tick <= 1'b1;
        @(posedge i_clock);
        i_osc_tick <= 1'b0;
        @(posedge i_clock);
      end
      chk(n_add, ta[k]);
      chk(n_drop, td[k]);
    end
    $display("test trim done");
    print_verdict();
  end
endmodule : rtc_control_calibration_tb_top
